// File: verilog/data_handling_pkg.sv
// shared constants and operation codes for the data handling datapath
package data_handling_pkg;
   // flag register bit positions
   localparam int FLAG_HALF_BIT  = 5;
   localparam int FLAG_IRQ_BIT   = 4;
   localparam int FLAG_NEG_BIT   = 3;
   localparam int FLAG_ZERO_BIT  = 2;
   localparam int FLAG_OVF_BIT   = 1;
   localparam int FLAG_CARRY_BIT = 0;
   // reset values, and the operands at which dec and inc overflow
   localparam logic [7:0]  ACC_RESET   = 8'h00;
   localparam logic [7:0]  FLAG_RESET  = 8'h10;
   localparam logic [15:0] SP_RESET    = 16'h00ff;
   localparam logic [7:0]  DEC_OVF_VAL = 8'h80;
   localparam logic [7:0]  INC_OVF_VAL = 8'h7f;

   // operations
   typedef enum logic [4:0] {
      OP_NONE,
      OP_CLEAR,
      OP_DEC,
      OP_INC,
      OP_LOAD,
      OP_LOAD_D,
      OP_STORE,
      OP_STORE_D,
      OP_PUSH,
      OP_PULL,
      OP_ROL,
      OP_ROR,
      OP_SHL,
      OP_SHL_D,
      OP_ASR,
      OP_SHR,
      OP_SHR_D,
      OP_COPY_B_TO_A,
      OP_COPY_A_TO_B
   } op_t;

   // operand target
   typedef enum logic [1:0] {
      TGT_MEM,
      TGT_ACC_A,
      TGT_ACC_B
   } target_t;
endpackage

// File: verilog/flag_eval.sv
// sign, zero and overflow evaluation for an 8- or 16-bit result
`timescale 1ns/1ps
module flag_eval (
   // result in
   input  wire logic [15:0] result,
   input  wire logic        wide,
   input  wire logic        carry,
   // flags out
   output logic             neg,
   output logic             zero,
   output logic             shift_ovf
);
   always_comb begin
      neg       = wide ? result[15] : result[7];
      zero      = wide ? (result == 16'h0000) : (result[7:0] == 8'h00);
      shift_ovf = neg ^ carry;
   end
endmodule // flag_eval

// File: verilog/data_handling_alu.sv
// data handling datapath: accumulators, stack pointer and condition flags
`timescale 1ns/1ps
module data_handling_alu (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   // request from sequencer
   input  wire logic                    op_valid,
   input  data_handling_pkg::op_t       op_code,
   input  data_handling_pkg::target_t   op_target,
   input  wire logic [15:0]             op_addr,
   // memory bus
   output logic                         mem_req,
   output logic                         mem_we,
   output logic [15:0]                  mem_addr,
   output logic [7:0]                   mem_wdata,
   input  wire logic                    mem_ack,
   input  wire logic [7:0]              mem_rdata,
   // architectural state
   input  wire logic                    sp_load,
   input  wire logic [15:0]             sp_load_value,
   output logic [7:0]                   acc_a,
   output logic [7:0]                   acc_b,
   output logic [15:0]                  stack_pointer,
   output logic [7:0]                   flag_register,
   // status
   output logic                         busy,
   output logic                         done
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_READ2,
      ST_WRITE,
      ST_WRITE2,
      ST_FINISH
   } state_t;

   logic rst_meta_reg;
   logic rst_sync_reg;
   logic rst_ok_n;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_ok_n = rst_sync_reg;

   state_t                      state_reg, state_next;
   data_handling_pkg::op_t      op_reg, op_next;
   data_handling_pkg::target_t  tgt_reg, tgt_next;
   logic [15:0] addr_reg, addr_next;
   logic [7:0]  opnd_reg, opnd_next;
   logic [7:0]  a_reg, a_next;
   logic [7:0]  b_reg, b_next;
   logic [15:0] sp_reg, sp_next;
   logic [7:0]  flag_reg, flag_next;
   logic        req_reg, req_next;
   logic        we_reg, we_next;
   logic [15:0] maddr_reg, maddr_next;
   logic [7:0]  wdata_reg, wdata_next;
   logic        done_reg, done_next;

   // operand result and flags computed from the fetched operand or the accumulators
   logic [15:0] res;
   logic        res_wide;
   logic        res_c;
   logic        f_n;
   logic        f_z;
   logic        f_sv;
   logic [7:0]  src8;
   logic [15:0] d_val;

   flag_eval u_flag_eval (
      .result    (res),
      .wide      (res_wide),
      .carry     (res_c),
      .neg       (f_n),
      .zero      (f_z),
      .shift_ovf (f_sv)
   );

   always_comb begin
      d_val    = {a_reg, b_reg};
      // loads and pulls take the fetched byte, not the target register
      if (op_reg == data_handling_pkg::OP_LOAD ||
          op_reg == data_handling_pkg::OP_PULL ||
          tgt_reg == data_handling_pkg::TGT_MEM) begin
         src8 = opnd_reg;
      end else if (tgt_reg == data_handling_pkg::TGT_ACC_A) begin
         src8 = a_reg;
      end else begin
         src8 = b_reg;
      end
      res      = {8'h00, src8};
      res_wide = 1'b0;
      res_c    = flag_reg[data_handling_pkg::FLAG_CARRY_BIT];
      unique case (op_reg)
         data_handling_pkg::OP_CLEAR: res = 16'h0000;
         data_handling_pkg::OP_DEC: res = {8'h00, src8 - 8'h01};
         data_handling_pkg::OP_INC: res = {8'h00, src8 + 8'h01};
         data_handling_pkg::OP_LOAD_D,
         data_handling_pkg::OP_STORE_D: begin
            res      = d_val;
            res_wide = 1'b1;
         end
         data_handling_pkg::OP_ROL: begin
            res   = {8'h00, src8[6:0], flag_reg[0]};
            res_c = src8[7];
         end
         data_handling_pkg::OP_ROR: begin
            res   = {8'h00, flag_reg[0], src8[7:1]};
            res_c = src8[0];
         end
         data_handling_pkg::OP_SHL: begin
            res   = {8'h00, src8[6:0], 1'b0};
            res_c = src8[7];
         end
         data_handling_pkg::OP_SHL_D: begin
            res      = {d_val[14:0], 1'b0};
            res_wide = 1'b1;
            res_c    = d_val[15];
         end
         data_handling_pkg::OP_ASR: begin
            res   = {8'h00, src8[7], src8[7:1]};
            res_c = src8[0];
         end
         data_handling_pkg::OP_SHR: begin
            res   = {8'h00, 1'b0, src8[7:1]};
            res_c = src8[0];
         end
         data_handling_pkg::OP_SHR_D: begin
            res      = {1'b0, d_val[15:1]};
            res_wide = 1'b1;
            res_c    = d_val[0];
         end
         data_handling_pkg::OP_COPY_B_TO_A: res = {8'h00, b_reg};
         data_handling_pkg::OP_COPY_A_TO_B: res = {8'h00, a_reg};
         default: res = {8'h00, src8};
      endcase
   end

   // flag update: H and I are always carried through unchanged
   function automatic logic [7:0] flags_nzvc(input logic [7:0] old,
                                             input logic n, input logic z,
                                             input logic v, input logic c);
      logic [7:0] f;
      f = old;
      f[data_handling_pkg::FLAG_NEG_BIT]   = n;
      f[data_handling_pkg::FLAG_ZERO_BIT]  = z;
      f[data_handling_pkg::FLAG_OVF_BIT]   = v;
      f[data_handling_pkg::FLAG_CARRY_BIT] = c;
      return f;
   endfunction

   always_comb begin
      logic oldc;
      oldc       = flag_reg[data_handling_pkg::FLAG_CARRY_BIT];
      state_next = state_reg;
      op_next    = op_reg;
      tgt_next   = tgt_reg;
      addr_next  = addr_reg;
      opnd_next  = opnd_reg;
      a_next     = a_reg;
      b_next     = b_reg;
      sp_next    = sp_load ? sp_load_value : sp_reg;
      flag_next  = flag_reg;
      req_next   = req_reg;
      we_next    = we_reg;
      maddr_next = maddr_reg;
      wdata_next = wdata_reg;
      done_next  = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (op_valid) begin
               op_next   = op_code;
               tgt_next  = op_target;
               addr_next = op_addr;
               unique case (op_code)
                  data_handling_pkg::OP_LOAD,
                  data_handling_pkg::OP_LOAD_D: begin
                     state_next = ST_READ;
                     req_next   = 1'b1;
                     we_next    = 1'b0;
                     maddr_next = op_addr;
                  end
                  data_handling_pkg::OP_PULL: begin
                     state_next = ST_READ;
                     req_next   = 1'b1;
                     we_next    = 1'b0;
                     sp_next    = sp_reg + 16'h0001;
                     maddr_next = sp_reg + 16'h0001;
                  end
                  data_handling_pkg::OP_STORE,
                  data_handling_pkg::OP_STORE_D,
                  data_handling_pkg::OP_PUSH: begin
                     state_next = ST_WRITE;
                     req_next   = 1'b1;
                     we_next    = 1'b1;
                     maddr_next = (op_code == data_handling_pkg::OP_PUSH) ?
                                  sp_reg : op_addr;
                     wdata_next = (op_code == data_handling_pkg::OP_STORE_D
                                   || op_target ==
                                   data_handling_pkg::TGT_ACC_A) ?
                                  a_reg : b_reg;
                  end
                  data_handling_pkg::OP_NONE: state_next = ST_IDLE;
                  default: begin
                     if (op_target == data_handling_pkg::TGT_MEM) begin
                        state_next = ST_READ;
                        req_next   = 1'b1;
                        we_next    = 1'b0;
                        maddr_next = op_addr;
                     end else begin
                        state_next = ST_FINISH;
                     end
                  end
               endcase
            end
         end
         ST_READ: begin
            if (mem_ack) begin
               req_next = 1'b0;
               if (op_reg == data_handling_pkg::OP_LOAD_D) begin
                  a_next     = mem_rdata;
                  state_next = ST_READ2;
                  req_next   = 1'b1;
                  maddr_next = addr_reg + 16'h0001;
               end else begin
                  opnd_next  = mem_rdata;
                  state_next = ST_FINISH;
               end
            end
         end
         ST_READ2: begin
            if (mem_ack) begin
               req_next   = 1'b0;
               b_next     = mem_rdata;
               state_next = ST_FINISH;
            end
         end
         ST_WRITE: begin
            if (mem_ack) begin
               req_next = 1'b0;
               if (op_reg == data_handling_pkg::OP_STORE_D) begin
                  state_next = ST_WRITE2;
                  req_next   = 1'b1;
                  maddr_next = addr_reg + 16'h0001;
                  wdata_next = b_reg;
               end else begin
                  state_next = ST_FINISH;
                  if (op_reg == data_handling_pkg::OP_PUSH) begin
                     sp_next = sp_reg - 16'h0001;
                  end
               end
            end
         end
         ST_WRITE2: begin
            if (mem_ack) begin
               req_next = 1'b0;
               if (op_reg == data_handling_pkg::OP_STORE_D) begin
                  state_next = ST_FINISH;
               end else begin
                  // write-back of a memory operand: flags already set
                  state_next = ST_IDLE;
                  done_next  = 1'b1;
                  we_next    = 1'b0;
               end
            end
         end
         ST_FINISH: begin
            state_next = ST_IDLE;
            done_next  = 1'b1;
            we_next    = 1'b0;
            unique case (op_reg)
               data_handling_pkg::OP_CLEAR:
                  flag_next = flags_nzvc(flag_reg, 1'b0, 1'b1, 1'b0,
                                         1'b0);
               data_handling_pkg::OP_DEC:
                  flag_next = flags_nzvc(flag_reg, f_n, f_z,
                     src8 == data_handling_pkg::DEC_OVF_VAL,
                     oldc);
               data_handling_pkg::OP_INC:
                  flag_next = flags_nzvc(flag_reg, f_n, f_z,
                     src8 == data_handling_pkg::INC_OVF_VAL,
                     oldc);
               data_handling_pkg::OP_LOAD,
               data_handling_pkg::OP_LOAD_D,
               data_handling_pkg::OP_STORE,
               data_handling_pkg::OP_STORE_D,
               data_handling_pkg::OP_COPY_B_TO_A,
               data_handling_pkg::OP_COPY_A_TO_B:
                  flag_next = flags_nzvc(flag_reg, f_n, f_z, 1'b0,
                                         oldc);
               data_handling_pkg::OP_ROL,
               data_handling_pkg::OP_ROR,
               data_handling_pkg::OP_SHL,
               data_handling_pkg::OP_SHL_D,
               data_handling_pkg::OP_ASR,
               data_handling_pkg::OP_SHR,
               data_handling_pkg::OP_SHR_D:
                  flag_next = flags_nzvc(flag_reg, f_n, f_z, f_sv,
                                         res_c);
               default: flag_next = flag_reg;
            endcase
            // write back the result
            unique case (op_reg)
               data_handling_pkg::OP_LOAD_D,
               data_handling_pkg::OP_SHL_D,
               data_handling_pkg::OP_SHR_D: begin
                  if (op_reg != data_handling_pkg::OP_LOAD_D) begin
                     a_next = res[15:8];
                     b_next = res[7:0];
                  end
               end
               data_handling_pkg::OP_PUSH,
               data_handling_pkg::OP_STORE,
               data_handling_pkg::OP_STORE_D,
               data_handling_pkg::OP_NONE: a_next = a_reg;
               data_handling_pkg::OP_COPY_B_TO_A: a_next = res[7:0];
               data_handling_pkg::OP_COPY_A_TO_B: b_next = res[7:0];
               default: begin
                  if (tgt_reg == data_handling_pkg::TGT_ACC_A) begin
                     a_next = res[7:0];
                  end else if (tgt_reg == data_handling_pkg::TGT_ACC_B) begin
                     b_next = res[7:0];
                  end else if (op_reg != data_handling_pkg::OP_LOAD &&
                               op_reg != data_handling_pkg::OP_PULL) begin
                     // memory target: write the result back
                     state_next = ST_WRITE2;
                     done_next  = 1'b0;
                     req_next   = 1'b1;
                     we_next    = 1'b1;
                     maddr_next = addr_reg;
                     wdata_next = res[7:0];
                  end
               end
            endcase
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         state_reg <= ST_IDLE;
         op_reg    <= data_handling_pkg::OP_NONE;
         tgt_reg   <= data_handling_pkg::TGT_MEM;
         addr_reg  <= 16'h0000;
         opnd_reg  <= data_handling_pkg::ACC_RESET;
         a_reg     <= data_handling_pkg::ACC_RESET;
         b_reg     <= data_handling_pkg::ACC_RESET;
         sp_reg    <= data_handling_pkg::SP_RESET;
         flag_reg  <= data_handling_pkg::FLAG_RESET;
         req_reg   <= 1'b0;
         we_reg    <= 1'b0;
         maddr_reg <= 16'h0000;
         wdata_reg <= 8'h00;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         op_reg    <= op_next;
         tgt_reg   <= tgt_next;
         addr_reg  <= addr_next;
         opnd_reg  <= opnd_next;
         a_reg     <= a_next;
         b_reg     <= b_next;
         sp_reg    <= sp_next;
         flag_reg  <= flag_next;
         req_reg   <= req_next;
         we_reg    <= we_next;
         maddr_reg <= maddr_next;
         wdata_reg <= wdata_next;
         done_reg  <= done_next;
      end
   end

   logic busy_reg;
   always_ff @(posedge sys_clk or negedge rst_ok_n) begin
      if (!rst_ok_n) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= (state_next != ST_IDLE);
      end
   end

   assign mem_req       = req_reg;
   assign mem_we        = we_reg;
   assign mem_addr      = maddr_reg;
   assign mem_wdata     = wdata_reg;
   assign acc_a         = a_reg;
   assign acc_b         = b_reg;
   assign stack_pointer = sp_reg;
   assign flag_register = flag_reg;
   assign busy          = busy_reg;
   assign done          = done_reg;

   // checks
   clear_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_ok_n)
      (state_reg == ST_FINISH && op_reg == data_handling_pkg::OP_CLEAR)
      |=> flag_reg[3:0] == 4'h4)
      else $error("clear flags wrong");
   carry_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_ok_n)
      (state_reg == ST_FINISH && (op_reg == data_handling_pkg::OP_INC ||
       op_reg == data_handling_pkg::OP_DEC))
      |=> $stable(flag_reg[0]))
      else $error("inc or dec changed carry");
   hi_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_ok_n)
      $stable(flag_reg[5:4]))
      else $error("half carry or mask changed");
   shift_ovf_a: assert property (@(posedge sys_clk) disable iff (!rst_ok_n)
      (state_reg == ST_FINISH && op_reg >= data_handling_pkg::OP_ROL &&
       op_reg <= data_handling_pkg::OP_SHR_D)
      |=> flag_reg[1] == (flag_reg[3] ^ flag_reg[0]))
      else $error("shift overflow not n xor c");
   push_sp_a: assert property (@(posedge sys_clk) disable iff (!rst_ok_n)
      (state_reg == ST_WRITE && op_reg == data_handling_pkg::OP_PUSH &&
       mem_ack && !sp_load) |=> sp_reg == $past(sp_reg) - 16'h0001)
      else $error("push did not decrement pointer");
   pull_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_ok_n)
      (state_reg == ST_IDLE && op_valid &&
       op_code == data_handling_pkg::OP_PULL && !sp_load)
      |=> mem_addr == sp_reg && mem_addr == $past(sp_reg) + 16'h0001)
      else $error("pull address wrong");
   shr_neg_a: assert property (@(posedge sys_clk) disable iff (!rst_ok_n)
      (state_reg == ST_FINISH && (op_reg == data_handling_pkg::OP_SHR ||
       op_reg == data_handling_pkg::OP_SHR_D)) |=> !flag_reg[3])
      else $error("logical shift right left n set");
   load_ovf_a: assert property (@(posedge sys_clk) disable iff (!rst_ok_n)
      (state_reg == ST_FINISH && op_reg == data_handling_pkg::OP_LOAD)
      ##1 1'b1 |-> !flag_reg[1] && flag_reg[0] == $past(flag_reg[0]))
      else $error("load flags wrong");
   cov_push_c: cover property (@(posedge sys_clk)
      state_reg == ST_WRITE && op_reg == data_handling_pkg::OP_PUSH && mem_ack);
   cov_rot_c: cover property (@(posedge sys_clk)
      state_reg == ST_FINISH && op_reg == data_handling_pkg::OP_ROR);
   cov_ldd_c: cover property (@(posedge sys_clk)
      state_reg == ST_READ2 && mem_ack);
endmodule // data_handling_alu

// File: dv/mem_model.sv
// byte memory partner with random acknowledge latency
`timescale 1ns/1ps
module mem_model (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // memory bus
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic             mem_ack,
   output logic [7:0]       mem_rdata
);
   logic [7:0] mem [256];
   int         wait_reg;

   // ack lasts one cycle; read data is scrambled whenever not acked
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack   <= 1'b0;
         wait_reg  <= 0;
         mem_rdata <= 8'h00;
      end else begin
         mem_ack <= 1'b0;
         if (mem_req && !mem_ack && wait_reg == 0) begin
            mem_ack  <= 1'b1;
            wait_reg <= $urandom_range(3, 0);
            if (mem_we)
               mem[mem_addr[7:0]] <= mem_wdata;
            else
               mem_rdata <= mem[mem_addr[7:0]];
         end else begin
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack)
               wait_reg <= wait_reg - 1;
         end
      end
   end
endmodule // mem_model

// File: dv/testbench.sv
// self-checking bench for the data handling datapath
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0;
   data_handling_pkg::op_t     op_code = data_handling_pkg::OP_NONE;
   data_handling_pkg::target_t op_target = data_handling_pkg::TGT_MEM;
   logic [15:0] op_addr = 16'h0000, mem_addr, stack_pointer;
   logic [15:0] sp_load_value = 16'h0000;
   logic sp_load = 1'b0, mem_req, mem_we, mem_ack, busy, done;
   logic [7:0] mem_wdata, mem_rdata, acc_a, acc_b, flag_register;
   logic [7:0] ra, rb, rf, rmem [256];
   logic [15:0] rsp;
   logic [39:0] exp_q [$];
   logic [39:0] ev;
   int miscompares = 0, checks_done = 0, cycles = 0;

   data_handling_alu u_data_handling_alu (.sys_clk(sys_clk), .rst_n(rst_n),
      .op_valid(op_valid), .op_code(op_code), .op_target(op_target),
      .op_addr(op_addr), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .sp_load(sp_load),
      .sp_load_value(sp_load_value), .acc_a(acc_a), .acc_b(acc_b),
      .stack_pointer(stack_pointer), .flag_register(flag_register),
      .busy(busy), .done(done));
   mem_model u_mem_model (.sys_clk(sys_clk), .rst_n(rst_n),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   always #50 sys_clk = ~sys_clk;

   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] expv);
      checks_done++;
      if (seen !== expv) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, expv, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // reference behaviour of one operation
   task automatic calc(input data_handling_pkg::op_t op,
                       input data_handling_pkg::target_t t,
                       input logic [7:0] ad);
      logic [7:0]  v, res;
      logic [15:0] d, dres;
      logic        c, ov, n, z, wide, sh, upd;
      v = (t == data_handling_pkg::TGT_MEM) ? rmem[ad] :
          (t == data_handling_pkg::TGT_ACC_A) ? ra : rb;
      d = {ra, rb};
      c = rf[0];
      ov = 1'b0;
      {wide, sh, upd} = 3'b001;
      res = v;
      dres = d;
      case (op)
         data_handling_pkg::OP_CLEAR: {res, c} = 9'h000;
         data_handling_pkg::OP_DEC: begin
            res = v - 8'h01;
            ov = (v == 8'h80);
         end
         data_handling_pkg::OP_INC: begin
            res = v + 8'h01;
            ov = (v == 8'h7f);
         end
         data_handling_pkg::OP_LOAD: res = rmem[ad];
         data_handling_pkg::OP_LOAD_D: begin
            wide = 1'b1;
            dres = {rmem[ad], rmem[ad + 8'h01]};
         end
         data_handling_pkg::OP_STORE: rmem[ad] = v;
         data_handling_pkg::OP_STORE_D: begin
            wide = 1'b1;
            {rmem[ad], rmem[ad + 8'h01]} = d;
         end
         data_handling_pkg::OP_PUSH: begin
            upd = 1'b0;
            rmem[rsp[7:0]] = v;
            rsp = rsp - 16'h0001;
         end
         data_handling_pkg::OP_PULL: begin
            upd = 1'b0;
            rsp = rsp + 16'h0001;
            res = rmem[rsp[7:0]];
         end
         data_handling_pkg::OP_ROL: {sh, c, res} = {1'b1, v, c};
         data_handling_pkg::OP_ROR: {sh, res, c} = {1'b1, c, v};
         data_handling_pkg::OP_SHL: {sh, c, res} = {1'b1, v, 1'b0};
         data_handling_pkg::OP_SHL_D: {wide, sh, c, dres} = {2'b11, d, 1'b0};
         data_handling_pkg::OP_ASR: {sh, res, c} = {1'b1, v[7], v};
         data_handling_pkg::OP_SHR: {sh, res, c} = {2'b10, v};
         data_handling_pkg::OP_SHR_D: {wide, sh, dres, c} = {3'b110, d};
         data_handling_pkg::OP_COPY_B_TO_A: begin
            t = data_handling_pkg::TGT_ACC_A;
            res = rb;
         end
         data_handling_pkg::OP_COPY_A_TO_B: begin
            t = data_handling_pkg::TGT_ACC_B;
            res = ra;
         end
         default: upd = 1'b0;
      endcase
      n = wide ? dres[15] : res[7];
      z = wide ? (dres == 16'h0000) : (res == 8'h00);
      if (sh)
         ov = n ^ c;
      if (upd)
         rf[3:0] = {n, z, ov, c};
      if (wide)
         {ra, rb} = dres;
      else if (t == data_handling_pkg::TGT_MEM)
         rmem[ad] = res;
      else if (t == data_handling_pkg::TGT_ACC_A)
         ra = res;
      else
         rb = res;
   endtask

   // issue one operation; a refused strobe may be offered while busy
   task automatic run_op(input data_handling_pkg::op_t op,
                         input data_handling_pkg::target_t t,
                         input logic [15:0] ad, input bit refuse);
      int n;
      calc(op, t, ad[7:0]);
      exp_q.push_back({ra, rb, rsp, rf});
      @(negedge sys_clk);
      op_valid = 1'b1;
      op_code = op;
      op_target = t;
      op_addr = ad;
      @(negedge sys_clk);
      op_code = data_handling_pkg::OP_CLEAR;
      op_valid = refuse;
      if (refuse)
         @(negedge sys_clk);
      op_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
   endtask

   always @(posedge sys_clk) begin
      if (done === 1'b1) begin
         ev = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
         check("acc_a", {8'h00, acc_a}, {8'h00, ev[39:32]});
         check("acc_b", {8'h00, acc_b}, {8'h00, ev[31:24]});
         check("stack_pointer", stack_pointer, ev[23:8]);
         check("flag_register", {8'h00, flag_register}, {8'h00, ev[7:0]});
      end
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      data_handling_pkg::op_t     op;
      data_handling_pkg::target_t t;
      void'($urandom(99));
      for (int i = 0; i < 256; i++)
         rmem[i] = 8'($urandom);
      {rmem[1], rmem[2], rmem[3], rmem[4]} = 32'h7f80aa00;
      for (int i = 0; i < 256; i++)
         u_mem_model.mem[i] = rmem[i];
      repeat (8) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      ra = data_handling_pkg::ACC_RESET;
      rb = data_handling_pkg::ACC_RESET;
      rsp = data_handling_pkg::SP_RESET;
      rf = data_handling_pkg::FLAG_RESET;
      check("reset flags", {8'h00, flag_register}, {8'h00, rf});
      check("reset pointer", stack_pointer, rsp);
      sp_load_value = {8'h01, 8'($urandom)};
      sp_load = 1'b1;
      @(negedge sys_clk);
      sp_load = 1'b0;
      rsp = sp_load_value;
      run_op(data_handling_pkg::OP_LOAD, data_handling_pkg::TGT_ACC_A, 16'h0001, 0);
      run_op(data_handling_pkg::OP_INC, data_handling_pkg::TGT_ACC_A, 16'h0000, 1);
      run_op(data_handling_pkg::OP_DEC, data_handling_pkg::TGT_ACC_A, 16'h0000, 0);
      run_op(data_handling_pkg::OP_DEC, data_handling_pkg::TGT_ACC_A, 16'h0000, 0);
      run_op(data_handling_pkg::OP_LOAD, data_handling_pkg::TGT_ACC_A, 16'h0003, 0);
      run_op(data_handling_pkg::OP_SHL, data_handling_pkg::TGT_ACC_A, 16'h0000, 0);
      run_op(data_handling_pkg::OP_LOAD, data_handling_pkg::TGT_ACC_A, 16'h0003, 0);
      run_op(data_handling_pkg::OP_ROR, data_handling_pkg::TGT_ACC_A, 16'h0000, 0);
      run_op(data_handling_pkg::OP_INC, data_handling_pkg::TGT_MEM, 16'h0001, 1);
      run_op(data_handling_pkg::OP_DEC, data_handling_pkg::TGT_MEM, 16'h0002, 0);
      for (int k = 1; k < 19; k++)
         run_op(data_handling_pkg::op_t'(k), data_handling_pkg::TGT_ACC_B,
                16'h0004, 0);
      repeat (250) begin
         op = data_handling_pkg::op_t'($urandom_range(18, 1));
         t = data_handling_pkg::target_t'($urandom_range(2, 0));
         if (t == data_handling_pkg::TGT_MEM &&
             op >= data_handling_pkg::OP_LOAD && op <= data_handling_pkg::OP_PULL)
            t = data_handling_pkg::TGT_ACC_A;
         run_op(op, t, 16'($urandom), 1'($urandom));
      end
      repeat (2) @(negedge sys_clk);
      for (int i = 0; i < 256; i++)
         check("memory", {8'h00, u_mem_model.mem[i]}, {8'h00, rmem[i]});
      finish_test();
   end
endmodule // testbench
